// file: rtl/cef_ctrl.sv
// comparator edge-flag controller: registers, flags, interrupt and input select
// Contract
// - rise enable bit 7 high: a low-to-high result sets that comparator's flag
// - fall enable bit 6 high: a high-to-low result sets that comparator's flag
// - mirror bit 1 always shows comparator two's result; writes there do nothing
// - mirror bit 0 always shows comparator one's result
// - unimplemented register bits read zero and ignore writes
// - mirror bits read zero after any reset
// - result is taken after the polarity stage, inverted when invert bit is one
`timescale 1ns/1ps
module cef_ctrl
    import cef_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire cef_bus_t busReq,
    input wire logic [CMP_COUNT-1:0] rawResult,
    output logic [DATA_W-1:0] regRdData,
    output logic irq,
    output cef_mux_t [CMP_COUNT-1:0] muxSel
);
    cef_state_t st;
    cef_state_t next_st;
    logic [CMP_COUNT-1:0] result;
    logic [CMP_COUNT-1:0] rise;
    logic [CMP_COUNT-1:0] fall;
    logic [CMP_COUNT-1:0] edgeHit;
    logic [CMP_COUNT-1:0] clearHit;

    function automatic logic hitReg(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base,
        input int idx
    );
        hitReg = (addr == (base + ADDR_W'(idx)));
    endfunction

    function automatic logic [3:0] oneHot(input logic [1:0] field);
        oneHot = 4'h1 << field;
    endfunction

    // one synchroniser and edge detector per comparator
    for (genvar g = 0; g < CMP_COUNT; g++) begin : g_cmp
        cef_result_sync u_sync (
            .clock(clock),
            .sys_rst(sys_rst),
            .clkEn(clkEn),
            .rawResult(rawResult[g]),
            .invert(st.invert[g]),
            .result(result[g]),
            .risePulse(rise[g]),
            .fallPulse(fall[g])
        );
    end

    assign edgeHit = (rise & st.riseEn) | (fall & st.fallEn);
    assign clearHit = (busReq.wr && busReq.addr == OFS_IRQ_CLEAR) ? busReq.wrData[CMP_COUNT-1:0] : '0;

    always_comb begin
        next_st = st;
        // read data stand for one cycle only
        next_st.rdData = 8'h00;
        for (int i = 0; i < CMP_COUNT; i++) begin
            // control register: only the polarity bit is stored
            if (busReq.wr && hitReg(busReq.addr, OFS_CTRL_BASE, i)) begin
                next_st.invert[i] = busReq.wrData[BIT_INVERT];
            end
            // edge enables and input selects; bits 3 and 2 are dropped
            if (busReq.wr && hitReg(busReq.addr, OFS_SEL_BASE, i)) begin
                next_st.riseEn[i] = busReq.wrData[BIT_RISE_EN];
                next_st.fallEn[i] = busReq.wrData[BIT_FALL_EN];
                next_st.plusField[i] = busReq.wrData[PLUS_LSB +: 2];
                next_st.minusField[i] = busReq.wrData[MINUS_LSB +: 2];
            end
            // a new edge wins over a clear in the same cycle
            next_st.flag[i] = (st.flag[i] & ~clearHit[i]) | edgeHit[i];
            next_st.mux[i].plusSel = oneHot(st.plusField[i]);
            next_st.mux[i].minusSel = oneHot(st.minusField[i]);
            if (busReq.rd && hitReg(busReq.addr, OFS_CTRL_BASE, i)) begin
                next_st.rdData[BIT_RESULT] = result[i];
                next_st.rdData[BIT_INVERT] = st.invert[i];
            end
            if (busReq.rd && hitReg(busReq.addr, OFS_SEL_BASE, i)) begin
                next_st.rdData[BIT_RISE_EN] = st.riseEn[i];
                next_st.rdData[BIT_FALL_EN] = st.fallEn[i];
                next_st.rdData[PLUS_LSB +: 2] = st.plusField[i];
                next_st.rdData[MINUS_LSB +: 2] = st.minusField[i];
            end
        end
        if (busReq.wr && busReq.addr == OFS_IRQ_ENABLE) begin
            next_st.irqEnable = busReq.wrData[CMP_COUNT-1:0];
        end
        // mirror and status are read only; upper bits stay zero
        if (busReq.rd) begin
            if (busReq.addr == OFS_MIRROR) begin
                next_st.rdData[CMP_COUNT-1:0] = result;
            end else if (busReq.addr == OFS_IRQ_STATUS) begin
                next_st.rdData[CMP_COUNT-1:0] = st.flag;
            end else if (busReq.addr == OFS_IRQ_ENABLE) begin
                next_st.rdData[CMP_COUNT-1:0] = st.irqEnable;
            end
        end
        next_st.irq = |(next_st.flag & next_st.irqEnable);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= STATE_RST;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign regRdData = st.rdData;
    assign irq = st.irq;
    assign muxSel = st.mux;

    // per-comparator checks
    for (genvar g = 0; g < CMP_COUNT; g++) begin : g_chk
        property p_rise_sets;
            @(posedge clock) disable iff (sys_rst)
            clkEn && rise[g] && st.riseEn[g] |=> st.flag[g];
        endproperty
        a_rise_sets: assert property (p_rise_sets)
            else $error("enabled rising edge did not set the flag");

        property p_rise_masked;
            @(posedge clock) disable iff (sys_rst)
            clkEn && rise[g] && !st.riseEn[g] && !st.flag[g] |=> !st.flag[g];
        endproperty
        a_rise_masked: assert property (p_rise_masked)
            else $error("disabled rising edge set the flag");

        property p_fall_sets;
            @(posedge clock) disable iff (sys_rst)
            clkEn && fall[g] && st.fallEn[g] |=> st.flag[g];
        endproperty
        a_fall_sets: assert property (p_fall_sets)
            else $error("enabled falling edge did not set the flag");

        property p_fall_masked;
            @(posedge clock) disable iff (sys_rst)
            clkEn && fall[g] && !st.fallEn[g] && !st.flag[g] |=> !st.flag[g];
        endproperty
        a_fall_masked: assert property (p_fall_masked)
            else $error("disabled falling edge set the flag");

        property p_plus_decode;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.wr && busReq.addr == OFS_SEL_BASE + ADDR_W'(g) ##1 clkEn
            |=> muxSel[g].plusSel == (4'h1 << $past(busReq.wrData[PLUS_LSB +: 2], 2));
        endproperty
        a_plus_decode: assert property (p_plus_decode)
            else $error("plus select not decoded from written field");

        property p_minus_decode;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.wr && busReq.addr == OFS_SEL_BASE + ADDR_W'(g) ##1 clkEn
            |=> muxSel[g].minusSel == (4'h1 << $past(busReq.wrData[MINUS_LSB +: 2], 2));
        endproperty
        a_minus_decode: assert property (p_minus_decode)
            else $error("minus select not decoded from written field");

        property p_set_beats_clear;
            @(posedge clock) disable iff (sys_rst)
            clkEn && edgeHit[g] && clearHit[g] |=> st.flag[g];
        endproperty
        a_set_beats_clear: assert property (p_set_beats_clear)
            else $error("edge lost against a clear in the same cycle");

        property p_clear_drops;
            @(posedge clock) disable iff (sys_rst)
            clkEn && clearHit[g] && !edgeHit[g] |=> !st.flag[g];
        endproperty
        a_clear_drops: assert property (p_clear_drops)
            else $error("clear did not drop the flag");

        property p_flag_sticky;
            @(posedge clock) disable iff (sys_rst)
            clkEn && st.flag[g] && !clearHit[g] |=> st.flag[g];
        endproperty
        a_flag_sticky: assert property (p_flag_sticky)
            else $error("flag dropped without a clear");

        property p_flag_needs_edge;
            @(posedge clock) disable iff (sys_rst)
            clkEn && !st.flag[g] && !edgeHit[g] |=> !st.flag[g];
        endproperty
        a_flag_needs_edge: assert property (p_flag_needs_edge)
            else $error("flag set without an enabled edge");

        property p_mux_onehot;
            @(posedge clock) disable iff (sys_rst)
            clkEn |=> $onehot(muxSel[g].plusSel) && $onehot(muxSel[g].minusSel);
        endproperty
        a_mux_onehot: assert property (p_mux_onehot)
            else $error("input select not one-hot");

        property p_ctrl_read;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.rd && busReq.addr == OFS_CTRL_BASE + ADDR_W'(g)
            |=> regRdData[BIT_RESULT] == $past(result[g]) && regRdData[BIT_INVERT] == $past(st.invert[g]);
        endproperty
        a_ctrl_read: assert property (p_ctrl_read)
            else $error("control read differs from result or polarity");

        property p_ctrl_spare_zero;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.rd && busReq.addr == OFS_CTRL_BASE + ADDR_W'(g)
            |=> regRdData[7] == 1'b0 && regRdData[5] == 1'b0 && regRdData[3:0] == 4'h0;
        endproperty
        a_ctrl_spare_zero: assert property (p_ctrl_spare_zero)
            else $error("control register spare bits not zero");

        property p_sel_read;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.rd && busReq.addr == OFS_SEL_BASE + ADDR_W'(g)
            |=> regRdData[BIT_RISE_EN] == $past(st.riseEn[g]) && regRdData[BIT_FALL_EN] == $past(st.fallEn[g])
                && regRdData[PLUS_LSB +: 2] == $past(st.plusField[g])
                && regRdData[MINUS_LSB +: 2] == $past(st.minusField[g]);
        endproperty
        a_sel_read: assert property (p_sel_read)
            else $error("select read differs from stored fields");

        property p_sel_write;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.wr && busReq.addr == OFS_SEL_BASE + ADDR_W'(g)
            |=> st.riseEn[g] == $past(busReq.wrData[BIT_RISE_EN])
                && st.fallEn[g] == $past(busReq.wrData[BIT_FALL_EN]);
        endproperty
        a_sel_write: assert property (p_sel_write)
            else $error("edge enables not stored");

        property p_invert_write;
            @(posedge clock) disable iff (sys_rst)
            clkEn && busReq.wr && busReq.addr == OFS_CTRL_BASE + ADDR_W'(g)
            |=> st.invert[g] == $past(busReq.wrData[BIT_INVERT]);
        endproperty
        a_invert_write: assert property (p_invert_write)
            else $error("polarity bit not stored");
    end

    property p_mirror_two;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == OFS_MIRROR |=> regRdData[1] == $past(result[1]);
    endproperty
    a_mirror_two: assert property (p_mirror_two)
        else $error("mirror bit 1 differs from comparator two");

    property p_mirror_one;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == OFS_MIRROR |=> regRdData[0] == $past(result[0]);
    endproperty
    a_mirror_one: assert property (p_mirror_one)
        else $error("mirror bit 0 differs from comparator one");

    property p_mirror_upper_zero;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == OFS_MIRROR |=> regRdData[7:2] == 6'h00;
    endproperty
    a_mirror_upper_zero: assert property (p_mirror_upper_zero)
        else $error("mirror upper bits not zero");

    property p_sel_gap_zero;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && (busReq.addr == OFS_SEL_BASE || busReq.addr == OFS_SEL_BASE + 4'h1)
        |=> regRdData[3:2] == 2'h0;
    endproperty
    a_sel_gap_zero: assert property (p_sel_gap_zero)
        else $error("select register bits 3 and 2 not zero");

    property p_mirror_reset;
        @(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> result == 2'h0 && st.flag == 2'h0;
    endproperty
    a_mirror_reset: assert property (p_mirror_reset)
        else $error("mirror not zero after reset");

    property p_irq_level;
        @(posedge clock) disable iff (sys_rst)
        irq == |(st.flag & st.irqEnable);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt line disagrees with enabled flags");

    property p_idle_read_zero;
        @(posedge clock) disable iff (sys_rst)
        clkEn && !busReq.rd |=> regRdData == 8'h00;
    endproperty
    a_idle_read_zero: assert property (p_idle_read_zero)
        else $error("read data not zero outside a read answer");

    property p_freeze;
        @(posedge clock) disable iff (sys_rst)
        !clkEn |=> $stable(st);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while the clock enable was low");

    property p_mirror_write_ignored;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.wr && busReq.addr == OFS_MIRROR
        |=> $stable(st.invert) && $stable(st.riseEn) && $stable(st.fallEn) && $stable(st.irqEnable)
            && $stable(st.plusField) && $stable(st.minusField);
    endproperty
    a_mirror_write_ignored: assert property (p_mirror_write_ignored)
        else $error("write to the mirror changed a setting");

    property p_unmapped_write_ignored;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.wr && busReq.addr[ADDR_W-1]
        |=> $stable(st.invert) && $stable(st.riseEn) && $stable(st.fallEn) && $stable(st.irqEnable)
            && $stable(st.plusField) && $stable(st.minusField);
    endproperty
    a_unmapped_write_ignored: assert property (p_unmapped_write_ignored)
        else $error("write to an unmapped address changed a setting");

    property p_unmapped_read_zero;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && (busReq.addr[ADDR_W-1] || busReq.addr == OFS_IRQ_CLEAR) |=> regRdData == 8'h00;
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero)
        else $error("unmapped or write-only address read not zero");

    property p_status_read;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == OFS_IRQ_STATUS
        |=> regRdData == {6'h00, $past(st.flag)};
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read differs from the flags");

    property p_enable_read;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == OFS_IRQ_ENABLE
        |=> regRdData == {6'h00, $past(st.irqEnable)};
    endproperty
    a_enable_read: assert property (p_enable_read)
        else $error("enable read differs from the stored enables");

    property p_enable_write;
        @(posedge clock) disable iff (sys_rst)
        clkEn && busReq.wr && busReq.addr == OFS_IRQ_ENABLE
        |=> st.irqEnable == $past(busReq.wrData[CMP_COUNT-1:0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("interrupt enables not stored");
endmodule

// file: rtl/cef_pkg.sv
// shared constants and types of the comparator edge-flag controller
package cef_pkg;
    localparam int CMP_COUNT = 2;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int SYNC_STAGES = 3;
    // register offsets, one per address; control and select take base plus comparator index
    localparam logic [ADDR_W-1:0] OFS_CTRL_BASE = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_MIRROR = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 4'h7;
    // field positions
    localparam int BIT_RISE_EN = 7;
    localparam int BIT_FALL_EN = 6;
    localparam int PLUS_LSB = 4;
    localparam int MINUS_LSB = 0;
    localparam int BIT_RESULT = 6;
    localparam int BIT_INVERT = 4;
    // plus input channel codes
    localparam logic [1:0] PLUS_PIN = 2'h0;
    localparam logic [1:0] PLUS_DAC = 2'h1;
    localparam logic [1:0] PLUS_FIXREF = 2'h2;
    localparam logic [1:0] PLUS_GND = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic wr;
        logic rd;
    } cef_bus_t;

    typedef struct packed {
        logic [3:0] plusSel;
        logic [3:0] minusSel;
    } cef_mux_t;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic stable;
        logic result;
        logic rise;
        logic fall;
    } cef_sync_t;

    typedef struct packed {
        logic [CMP_COUNT-1:0] invert;
        logic [CMP_COUNT-1:0] riseEn;
        logic [CMP_COUNT-1:0] fallEn;
        logic [CMP_COUNT-1:0][1:0] plusField;
        logic [CMP_COUNT-1:0][1:0] minusField;
        logic [CMP_COUNT-1:0] flag;
        logic [CMP_COUNT-1:0] irqEnable;
        logic irq;
        logic [DATA_W-1:0] rdData;
        cef_mux_t [CMP_COUNT-1:0] mux;
    } cef_state_t;

    localparam cef_sync_t SYNC_RST = '0;
    localparam cef_state_t STATE_RST = '0;
endpackage

// file: rtl/cef_result_sync.sv
// synchroniser, polarity stage and edge detector for one comparator output
`timescale 1ns/1ps
module cef_result_sync
    import cef_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic rawResult,
    input wire logic invert,
    output logic result,
    output logic risePulse,
    output logic fallPulse
);
    cef_sync_t st;
    cef_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[SYNC_STAGES-2:0], rawResult};
        // accept a new level once the last two stages agree
        if (st.sync[1] == st.sync[2]) begin
            next_st.stable = st.sync[2];
        end
        next_st.result = next_st.stable ^ invert;
        next_st.rise = ~st.result & next_st.result;
        next_st.fall = st.result & ~next_st.result;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st <= SYNC_RST;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign result = st.result;
    assign risePulse = st.rise;
    assign fallPulse = st.fall;

    property p_polarity;
        @(posedge clock) disable iff (sys_rst)
        clkEn && st.sync[1] == st.sync[2] |=> st.result == ($past(st.sync[2]) ^ $past(invert));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("result does not follow settled level and polarity");

    property p_hold_while_unsettled;
        @(posedge clock) disable iff (sys_rst)
        clkEn && st.sync[1] != st.sync[2] && $stable(invert) |=> $stable(st.result);
    endproperty
    a_hold_while_unsettled: assert property (p_hold_while_unsettled)
        else $error("result changed before the synchroniser settled");
endmodule

// file: tb/cef_cmp_model.sv
// behavioural comparator cores with their input multiplexers
`timescale 1ns/1ps
module cef_cmp_model
    import cef_pkg::*;
(
    input wire cef_mux_t [CMP_COUNT-1:0] muxSel,
    input wire logic [CMP_COUNT-1:0][3:0][7:0] plusLvl,
    input wire logic [CMP_COUNT-1:0][3:0][7:0] minusLvl,
    output logic [CMP_COUNT-1:0] rawResult
);
    logic [CMP_COUNT-1:0][7:0] plusV;
    logic [CMP_COUNT-1:0][7:0] minusV;

    // an unselected input reads zero, so an unselected plus input gives a low result
    always_comb begin
        for (int i = 0; i < CMP_COUNT; i++) begin
            plusV[i] = 8'h00;
            minusV[i] = 8'h00;
            for (int k = 0; k < 4; k++) begin
                if (muxSel[i].plusSel[k]) begin
                    plusV[i] = plusLvl[i][k];
                end
                if (muxSel[i].minusSel[k]) begin
                    minusV[i] = minusLvl[i][k];
                end
            end
            rawResult[i] = plusV[i] > minusV[i];
        end
    end
endmodule

// file: tb/cef_ctrl_tb_top.sv
// self-checking testbench of the comparator edge-flag controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module cef_ctrl_tb_top;
    import cef_pkg::*;
    logic clock;
    logic sysRst;
    logic clkEn;
    cef_bus_t busReq;
    logic [CMP_COUNT-1:0] rawResult;
    logic [DATA_W-1:0] regRdData;
    logic irq;
    cef_mux_t [CMP_COUNT-1:0] muxSel;
    logic [CMP_COUNT-1:0][3:0][7:0] plusLvl;
    logic [CMP_COUNT-1:0][3:0][7:0] minusLvl;
    int fails;
    int checks;
    int cycles;

    cef_ctrl i_cef_ctrl (.clock(clock), .sys_rst(sysRst), .clkEn(clkEn), .busReq(busReq),
        .rawResult(rawResult), .regRdData(regRdData), .irq(irq), .muxSel(muxSel));
    cef_cmp_model i_cef_cmp_model (.muxSel(muxSel), .plusLvl(plusLvl), .minusLvl(minusLvl),
        .rawResult(rawResult));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic pulse_reset();
        sysRst <= 1'b1;
        repeat (6) @(posedge clock);
        sysRst <= 1'b0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        busReq.wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
        @(posedge clock);
        busReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        busReq.rd <= 1'b0;
        #1;
        `CHK(nm, e, regRdData)
    endtask

    // raise or drop comparator idx's plus pin above or below every minus level
    task automatic drive_plus(input int idx, input logic [7:0] lvl);
        @(posedge clock);
        plusLvl[idx][0] <= lvl;
        wait_cyc(8);
    endtask

    task automatic edge_test(input int idx);
        logic [7:0] bitV;
        bitV = 8'h01 << idx;
        wr(OFS_SEL_BASE + 4'(idx), 8'h80);
        drive_plus(idx, 8'h30);
        rd(OFS_MIRROR, bitV, "mirror high");
        rd(OFS_IRQ_STATUS, bitV, "rise flag");
        `CHK("irq enabled", 1'b1, irq)
        wr(OFS_IRQ_ENABLE, 8'h00);
        wait_cyc(2);
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_IRQ_ENABLE, 8'h03);
        wr(OFS_IRQ_CLEAR, bitV);
        rd(OFS_IRQ_STATUS, 8'h00, "cleared");
        drive_plus(idx, 8'h10);
        rd(OFS_IRQ_STATUS, 8'h00, "fall off");
        rd(OFS_MIRROR, 8'h00, "mirror low");
        `CHK("irq idle", 1'b0, irq)
        wr(OFS_SEL_BASE + 4'(idx), 8'h40);
        drive_plus(idx, 8'h30);
        rd(OFS_IRQ_STATUS, 8'h00, "rise off");
        drive_plus(idx, 8'h10);
        rd(OFS_IRQ_STATUS, bitV, "fall flag");
        wr(OFS_IRQ_CLEAR, bitV);
        drive_plus(idx, 8'h30);
        // clear lands in the cycle the fall is seen
        @(posedge clock);
        plusLvl[idx][0] <= 8'h10;
        wait_cyc(3);
        wr(OFS_IRQ_CLEAR, bitV);
        rd(OFS_IRQ_STATUS, bitV, "set beats clear");
        wr(OFS_IRQ_CLEAR, bitV);
        rd(OFS_IRQ_STATUS, 8'h00, "cleared again");
        $display("test edge flags comparator %0d done", idx);
    endtask

    initial begin
        sysRst = 1'b1;
        clkEn = 1'b1;
        busReq = '0;
        plusLvl = {8{8'h10}};
        minusLvl = {8{8'h20}};
        fails = 0;
        checks = 0;
        cycles = 0;
        pulse_reset();
        wait_cyc(2);
        for (int i = 0; i < CMP_COUNT; i++) begin
            `CHK("mux after reset", 8'h11, muxSel[i])
        end
        rd(OFS_MIRROR, 8'h00, "mirror reset");
        rd(4'h9, 8'h00, "unmapped");
        for (int i = 0; i < CMP_COUNT; i++) begin
            wr(OFS_SEL_BASE + 4'(i), 8'hFF);
            rd(OFS_SEL_BASE + 4'(i), 8'hF3, "select spare bits");
        end
        wr(OFS_MIRROR, 8'hFF);
        rd(OFS_MIRROR, 8'h00, "mirror write");
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(OFS_SEL_BASE, {2'b00, 2'(p), 2'b00, 2'(m)});
                wait_cyc(3);
                `CHK("mux decode", {4'h1 << p, 4'h1 << m}, muxSel[0])
            end
        end
        wr(OFS_SEL_BASE + 4'h1, 8'h32);
        wait_cyc(3);
        `CHK("mux decode two", 8'h84, muxSel[1])
        $display("test input select done");
        wr(OFS_IRQ_ENABLE, 8'h03);
        for (int i = 0; i < CMP_COUNT; i++) begin
            edge_test(i);
        end
        wr(OFS_CTRL_BASE, 8'h10);
        wait_cyc(8);
        rd(OFS_CTRL_BASE, 8'h50, "inverted result");
        rd(OFS_MIRROR, 8'h01, "inverted mirror");
        // write with clock enable low is lost
        wait_cyc(1);
        clkEn <= 1'b0;
        wr(OFS_IRQ_ENABLE, 8'h00);
        clkEn <= 1'b1;
        rd(OFS_IRQ_ENABLE, 8'h03, "frozen write");
        // comparator two high going into reset
        drive_plus(1, 8'h30);
        pulse_reset();
        rd(OFS_MIRROR, 8'h00, "mirror second reset");
        rd(OFS_IRQ_STATUS, 8'h00, "status second reset");
        wait_cyc(8);
        rd(OFS_MIRROR, 8'h02, "mirror after resync");
        $display("test polarity and reset done");
        print_verdict();
    end
endmodule
